// [core/ogf_core.sv]
// Optical gate command, acknowledge and fault handling logic
`timescale 1ns/1ns
`default_nettype none
`include "ogf_defs.svh"

module ogf_core
	import ogf_pkg::*;
#(
	parameter int T_ON_NS      = `OGF_T_ON_NS,
	parameter int T_OFF_NS     = `OGF_T_OFF_NS,
	parameter int T_ACK_NS     = `OGF_T_ACK_NS,
	parameter int T_SC_REP_NS  = `OGF_T_SC_REP_NS,
	parameter int T_SC_HOLD_NS = `OGF_T_SC_HOLD_NS,
	parameter int T_FILTER_NS  = `OGF_T_FILTER_NS
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic clk_en,
	input  wire logic optical_command_input,
	input  wire logic desat_detect,
	input  wire logic supply_low_lockout,
	input  wire logic gate_feedback_main,
	input  wire logic parallel_port_a_present,
	input  wire logic parallel_port_a_gate_feedback,
	input  wire logic parallel_port_b_present,
	input  wire logic parallel_port_b_gate_feedback,
	output logic      gate_drive,
	output logic      parallel_port_a_gate_cmd,
	output logic      parallel_port_b_gate_cmd,
	output logic      optical_status_output,
	output logic      status_led
);

	// Time in ns to whole cycles, rounded up, at least one
	function automatic int cyc_up(input int t_ns);
		int c;
		c = (t_ns * `OGF_CLK_MHZ + `OGF_NS_PER_US - 1) / `OGF_NS_PER_US;
		return (c < 1) ? 1 : c;
	endfunction

	// Counter reaches the last cycle of a span
	function automatic logic cnt_hit(input ogf_cnt_t cnt, input ogf_cnt_t lim);
		return cnt == (lim - `OGF_CNT_ONE);
	endfunction

	// Counter advance by one
	function automatic ogf_cnt_t cnt_inc(input ogf_cnt_t cnt);
		return cnt + `OGF_CNT_ONE;
	endfunction

	localparam ogf_cnt_t ON_CYC      = ogf_cnt_t'(cyc_up(T_ON_NS));
	localparam ogf_cnt_t OFF_CYC     = ogf_cnt_t'(cyc_up(T_OFF_NS));
	localparam ogf_cnt_t ACK_CYC     = ogf_cnt_t'(cyc_up(T_ACK_NS));
	localparam ogf_cnt_t SC_REP_CYC  = ogf_cnt_t'(cyc_up(T_SC_REP_NS));
	localparam ogf_cnt_t SC_HOLD_CYC = ogf_cnt_t'(cyc_up(T_SC_HOLD_NS));
	localparam ogf_cnt_t FILTER_CYC  = ogf_cnt_t'(cyc_up(T_FILTER_NS));

	localparam ogf_state_s RESET_STATE = '{
		cmd_s1:    `OGF_CMD_RESET,
		cmd_s2:    `OGF_CMD_RESET,
		cmd_prev:  `OGF_CMD_RESET,
		desat_s1:  `OGF_FB_RESET,
		desat_s2:  `OGF_FB_RESET,
		uv_s1:     `OGF_UV_RESET,
		uv_s2:     `OGF_UV_RESET,
		fbm_s1:    `OGF_FB_RESET,
		fbm_s2:    `OGF_FB_RESET,
		fba_s1:    `OGF_FB_RESET,
		fba_s2:    `OGF_FB_RESET,
		fbb_s1:    `OGF_FB_RESET,
		fbb_s2:    `OGF_FB_RESET,
		pra_s1:    `OGF_FB_RESET,
		pra_s2:    `OGF_FB_RESET,
		prb_s1:    `OGF_FB_RESET,
		prb_s2:    `OGF_FB_RESET,
		req:       `OGF_OUT_RESET,
		armed:     `OGF_OUT_RESET,
		uv:        `OGF_UV_RESET,
		sc:        OGF_SC_IDLE,
		sc_cnt:    `OGF_CNT_ZERO,
		gate:      `OGF_OUT_RESET,
		dly_cnt:   `OGF_CNT_ZERO,
		mon_cnt:   `OGF_CNT_ZERO,
		mon_fault: `OGF_OUT_RESET,
		ack_cnt:   `OGF_CNT_ZERO,
		status:    `OGF_OUT_RESET,
		led:       `OGF_OUT_RESET
	};

	ogf_state_s s_q;
	ogf_state_s s_d;

	always_comb begin
		logic     rise;
		logic     fall;
		logic     sc_detect;
		logic     mismatch;
		logic     mon_trip;
		logic     shutoff;
		logic     want;
		logic     fault;
		ogf_cnt_t lim;
		rise      = 1'b0;
		fall      = 1'b0;
		sc_detect = 1'b0;
		mismatch  = 1'b0;
		mon_trip  = 1'b0;
		shutoff   = 1'b0;
		want      = 1'b0;
		fault     = 1'b0;
		lim       = `OGF_CNT_ZERO;
		s_d       = s_q;

		if (clk_en) begin
			// Pin synchronisers
			s_d.cmd_s1   = optical_command_input;
			s_d.cmd_s2   = s_q.cmd_s1;
			s_d.cmd_prev = s_q.cmd_s2;
			s_d.desat_s1 = desat_detect;
			s_d.desat_s2 = s_q.desat_s1;
			s_d.uv_s1    = supply_low_lockout;
			s_d.uv_s2    = s_q.uv_s1;
			s_d.fbm_s1   = gate_feedback_main;
			s_d.fbm_s2   = s_q.fbm_s1;
			s_d.fba_s1   = parallel_port_a_gate_feedback;
			s_d.fba_s2   = s_q.fba_s1;
			s_d.fbb_s1   = parallel_port_b_gate_feedback;
			s_d.fbb_s2   = s_q.fbb_s1;
			s_d.pra_s1   = parallel_port_a_present;
			s_d.pra_s2   = s_q.pra_s1;
			s_d.prb_s1   = parallel_port_b_present;
			s_d.prb_s2   = s_q.prb_s1;

			// Edge detection on the synchronised command
			rise = s_q.cmd_s2 & ~s_q.cmd_prev;
			fall = ~s_q.cmd_s2 & s_q.cmd_prev;

			// Commanded state tracks the last edge
			if (rise) begin
				s_d.req = 1'b1;
			end else if (fall) begin
				s_d.req = 1'b0;
			end

			// Undervoltage, held from power-up until supply is good
			s_d.uv = s_q.uv_s2;

			// Short circuit: report delay, then hold
			case (s_q.sc)
				OGF_SC_IDLE: begin
					if (s_q.desat_s2 && s_q.gate) begin
						sc_detect  = 1'b1;
						s_d.sc     = OGF_SC_REPORT;
						s_d.sc_cnt = `OGF_CNT_ZERO;
					end
				end
				OGF_SC_REPORT: begin
					if (cnt_hit(s_q.sc_cnt, SC_REP_CYC)) begin
						s_d.sc     = OGF_SC_HOLD;
						s_d.sc_cnt = `OGF_CNT_ZERO;
					end else begin
						s_d.sc_cnt = cnt_inc(s_q.sc_cnt);
					end
				end
				OGF_SC_HOLD: begin
					if (cnt_hit(s_q.sc_cnt, SC_HOLD_CYC)) begin
						s_d.sc     = OGF_SC_IDLE;
						s_d.sc_cnt = `OGF_CNT_ZERO;
					end else begin
						s_d.sc_cnt = cnt_inc(s_q.sc_cnt);
					end
				end
				default: begin
					s_d.sc     = OGF_SC_IDLE;
					s_d.sc_cnt = `OGF_CNT_ZERO;
				end
			endcase

			// Gate monitoring over main and present peripherals
			mismatch = (s_q.fbm_s2 != s_q.gate)
				| (s_q.pra_s2 & (s_q.fba_s2 != s_q.gate))
				| (s_q.prb_s2 & (s_q.fbb_s2 != s_q.gate));
			if (mismatch) begin
				if (s_q.mon_fault) begin
					s_d.mon_fault = 1'b1;
				end else if (cnt_hit(s_q.mon_cnt, FILTER_CYC)) begin
					s_d.mon_fault = 1'b1;
					mon_trip      = 1'b1;
				end else begin
					s_d.mon_cnt = cnt_inc(s_q.mon_cnt);
				end
			end else begin
				s_d.mon_cnt   = `OGF_CNT_ZERO;
				s_d.mon_fault = 1'b0;
			end

			// Faults that force the gate off at once
			shutoff = sc_detect | s_q.uv | (mon_trip & s_q.gate);

			// Arming needs a fresh rising edge after any lockout
			if (rise && s_q.sc == OGF_SC_IDLE && !s_q.uv) begin
				s_d.armed = 1'b1;
			end
			if (shutoff || s_q.sc != OGF_SC_IDLE) begin
				s_d.armed = 1'b0;
			end

			want = s_q.req & s_q.armed & ~s_q.uv & (s_q.sc == OGF_SC_IDLE);

			// Gate with separate turn-on and turn-off delays
			if (shutoff || s_q.sc != OGF_SC_IDLE) begin
				s_d.gate    = 1'b0;
				s_d.dly_cnt = `OGF_CNT_ZERO;
			end else if (want != s_q.gate) begin
				lim = want ? ON_CYC : OFF_CYC;
				if (cnt_hit(s_q.dly_cnt, lim)) begin
					s_d.gate    = want;
					s_d.dly_cnt = `OGF_CNT_ZERO;
				end else begin
					s_d.dly_cnt = cnt_inc(s_q.dly_cnt);
				end
			end else begin
				s_d.dly_cnt = `OGF_CNT_ZERO;
			end

			// Acknowledge pulse on every command edge, restarted by a new edge
			if (rise || fall) begin
				s_d.ack_cnt = ACK_CYC;
			end else if (s_q.ack_cnt != `OGF_CNT_ZERO) begin
				s_d.ack_cnt = s_q.ack_cnt - `OGF_CNT_ONE;
			end

			// Status light and indicator
			fault = s_d.uv | (s_d.sc == OGF_SC_HOLD) | s_d.mon_fault;
			s_d.status = ~fault & (s_d.ack_cnt == `OGF_CNT_ZERO);
			s_d.led    = ~fault;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// One gate state drives main and both paralleling ports
	assign gate_drive               = s_q.gate;
	assign parallel_port_a_gate_cmd = s_q.gate;
	assign parallel_port_b_gate_cmd = s_q.gate;
	assign optical_status_output    = s_q.status;
	assign status_led               = s_q.led;

endmodule

`default_nettype wire

// [core/ogf_defs.svh]
// Constants for the optical gate command and fault logic
`ifndef OGF_DEFS_SVH
`define OGF_DEFS_SVH

`define OGF_CLK_MHZ        10
`define OGF_NS_PER_US      1000
`define OGF_CNT_W          16
`define OGF_CNT_ZERO       16'h0000
`define OGF_CNT_ONE        16'h0001

`define OGF_T_ON_NS        500
`define OGF_T_OFF_NS       500
`define OGF_T_ACK_NS       1000
`define OGF_T_SC_REP_NS    2000
`define OGF_T_SC_HOLD_NS   100000
`define OGF_T_FILTER_NS    5000

`define OGF_CMD_RESET      1'b0
`define OGF_UV_RESET       1'b1
`define OGF_FB_RESET       1'b0
`define OGF_OUT_RESET      1'b0

`endif

// [core/ogf_pkg.sv]
// Types for the optical gate command and fault logic
`include "ogf_defs.svh"

package ogf_pkg;

	typedef logic [`OGF_CNT_W-1:0] ogf_cnt_t;

	typedef enum logic [1:0] {
		OGF_SC_IDLE,
		OGF_SC_REPORT,
		OGF_SC_HOLD
	} ogf_sc_e;

	typedef struct packed {
		logic     cmd_s1;
		logic     cmd_s2;
		logic     cmd_prev;
		logic     desat_s1;
		logic     desat_s2;
		logic     uv_s1;
		logic     uv_s2;
		logic     fbm_s1;
		logic     fbm_s2;
		logic     fba_s1;
		logic     fba_s2;
		logic     fbb_s1;
		logic     fbb_s2;
		logic     pra_s1;
		logic     pra_s2;
		logic     prb_s1;
		logic     prb_s2;
		logic     req;
		logic     armed;
		logic     uv;
		ogf_sc_e  sc;
		ogf_cnt_t sc_cnt;
		logic     gate;
		ogf_cnt_t dly_cnt;
		ogf_cnt_t mon_cnt;
		logic     mon_fault;
		ogf_cnt_t ack_cnt;
		logic     status;
		logic     led;
	} ogf_state_s;

endpackage

// [verif/ogf_properties.sv]
// Port-level property checker for ogf_core
`timescale 1ns/1ns
`default_nettype none
module ogf_properties #(
	parameter int T_SC_REP_NS = 2000,
	parameter int T_FILTER_NS = 5000
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic optical_command_input,
	input wire logic desat_detect,
	input wire logic supply_low_lockout,
	input wire logic gate_feedback_main,
	input wire logic gate_drive,
	input wire logic parallel_port_a_gate_cmd,
	input wire logic parallel_port_b_gate_cmd,
	input wire logic optical_status_output,
	input wire logic status_led
);
	localparam int REP_LO = T_SC_REP_NS / 100 - 2;
	localparam int REP_HI = T_SC_REP_NS / 100 + 6;
	localparam int FILT   = T_FILTER_NS / 100 - 4;
	logic [7:0] hi_q;
	logic [7:0] mis_q;
	// Run lengths of command high and gate mismatch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hi_q  <= 8'h00;
			mis_q <= 8'h00;
		end else begin
			hi_q  <= optical_command_input ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
			mis_q <= gate_feedback_main != gate_drive ? mis_q + {7'h00, mis_q != 8'hff} : 8'h00;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	// Frozen cycles carry no timing obligations
	default disable iff (!rstn || !clk_en);
	a_ports_follow: assert property (
		parallel_port_a_gate_cmd == gate_drive && parallel_port_b_gate_cmd == gate_drive)
		else $error("port command differs");
	a_uv_lock: assert property (
		supply_low_lockout [*5] |=> !gate_drive && !optical_status_output && !status_led)
		else $error("undervoltage not locked");
	a_ack_pulse: assert property (
		$changed(optical_command_input) |-> ##[1:5] !optical_status_output [*8])
		else $error("ack pulse missing");
	a_off_delay: assert property (
		$fell(optical_command_input) && gate_drive |-> gate_drive [*3] ##[1:10] !gate_drive)
		else $error("turn-off timing");
	a_sc_gate_off: assert property (
		$rose(desat_detect) && gate_drive |-> ##[1:5] !gate_drive)
		else $error("short circuit gate on");
	a_sc_report: assert property (
		$rose(desat_detect) && gate_drive && status_led |-> ##[REP_LO:REP_HI] !status_led)
		else $error("short circuit report");
	a_no_reenable: assert property (
		$rose(gate_drive) |-> hi_q < 8'h14)
		else $error("gate on without fresh edge");
	a_mon_trip: assert property (
		mis_q == 8'(FILT) |-> ##[1:16] !status_led && !gate_drive)
		else $error("monitor trip missing");
	c_gate_on: cover property ($rose(gate_drive));
	c_sc_trip: cover property ($rose(desat_detect) && gate_drive);
	c_mon_trip: cover property (mis_q == 8'(FILT));
endmodule
bind ogf_core ogf_properties #(.T_SC_REP_NS(T_SC_REP_NS), .T_FILTER_NS(T_FILTER_NS))
	u_props (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
	.optical_command_input(optical_command_input),
	.desat_detect(desat_detect), .supply_low_lockout(supply_low_lockout),
	.gate_feedback_main(gate_feedback_main), .gate_drive(gate_drive),
	.parallel_port_a_gate_cmd(parallel_port_a_gate_cmd),
	.parallel_port_b_gate_cmd(parallel_port_b_gate_cmd),
	.optical_status_output(optical_status_output), .status_led(status_led));
`default_nettype wire

// [verif/ogf_host_model.sv]
// Host controller model on the optical links
`timescale 1ns/1ns
`default_nettype none
module ogf_host_model (
	input  wire logic       mclk,
	input  wire logic       want,
	input  wire logic       status,
	output wire logic       cmd,
	output wire logic [7:0] acks
);
	logic       seen_q = 1'h1;
	logic [7:0] acks_q = 8'h00;
	assign cmd  = want;
	assign acks = acks_q;
	// Counts light-off pulses; a missing one flags driver or link
	always @(posedge mclk) begin
		if (seen_q && !status)
			acks_q <= acks_q + 8'h01;
		seen_q <= status;
	end
endmodule
`default_nettype wire

// [verif/test_optical_gate_command_fault_logic.sv]
// Testbench for the optical gate command and fault logic
`timescale 1ns/1ns
`default_nettype none
module test_optical_gate_command_fault_logic;
	logic       mclk  = 1'h0;
	logic       rstn  = 1'h0;
	logic       want  = 1'h0;
	logic       desat = 1'h0;
	logic       uv    = 1'h1;
	logic       stuck = 1'h0;
	logic       en    = 1'h1;
	logic       pr_b  = 1'h1;
	logic       stk_b = 1'h0;
	logic       cmd, gate, pga, pgb, st, led;
	logic [7:0] acks;
	int         fails = 0;
	int         cmp_count = 0;
	always #50 mclk = ~mclk;
	ogf_host_model host (.mclk(mclk), .want(want), .status(st), .cmd(cmd), .acks(acks));
	ogf_core #(.T_SC_HOLD_NS(2000)) uut (.mclk(mclk), .rstn(rstn), .clk_en(en),
		.optical_command_input(cmd), .desat_detect(desat), .supply_low_lockout(uv),
		.gate_feedback_main(gate & ~stuck), .parallel_port_a_present(1'h1),
		.parallel_port_a_gate_feedback(gate), .parallel_port_b_present(pr_b),
		.parallel_port_b_gate_feedback(gate & ~stk_b), .gate_drive(gate),
		.parallel_port_a_gate_cmd(pga), .parallel_port_b_gate_cmd(pgb),
		.optical_status_output(st), .status_led(led));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic t_power_up;
		cyc(30);
		chk({st, led}, 2'h0);
		uv = 1'h0;
		cyc(10);
		chk({st, led}, 2'h3);
	endtask
	task automatic t_on_off;
		logic [7:0] a0;
		a0 = acks;
		want = 1'h1;
		cyc(5);
		chk({gate, st, led}, 3'h1);
		cyc(15);
		chk({gate, pga, pgb, st}, 4'hf);
		want = 1'h0;
		cyc(4);
		chk(gate, 1'h1);
		cyc(16);
		chk({gate, pga, pgb}, 3'h0);
		chk(acks, a0 + 8'h02);
	endtask
	task automatic t_short;
		want = 1'h1;
		cyc(20);
		desat = 1'h1;
		cyc(5);
		chk({gate, st}, 2'h1);
		desat = 1'h0;
		cyc(23);
		chk({st, led}, 2'h0);
		cyc(12);
		chk(st, 1'h0);
		cyc(20);
		chk({gate, st}, 2'h1);
		want = 1'h0;
		cyc(20);
		want = 1'h1;
		cyc(20);
		chk(gate, 1'h1);
		want = 1'h0;
		cyc(20);
	endtask
	task automatic t_uv;
		want = 1'h1;
		cyc(20);
		uv = 1'h1;
		cyc(26);
		chk({gate, st, led}, 3'h0);
		uv = 1'h0;
		cyc(8);
		chk({gate, st, led}, 3'h3);
		want = 1'h0;
		cyc(20);
	endtask
	task automatic t_monitor;
		int i;
		stuck = 1'h1;
		want = 1'h1;
		for (i = 0; i < 120 && led === 1'h1; i++)
			cyc(1);
		chk(i >= 55 && i <= 66, 1'h1);
		cyc(2);
		chk(gate, 1'h0);
		stuck = 1'h0;
		want = 1'h0;
		cyc(20);
		chk(led, 1'h1);
	endtask
	task automatic t_freeze;
		en   = 1'h0;
		want = 1'h1;
		cyc(6);
		chk({gate, st}, 2'h1);
		en = 1'h1;
		cyc(14);
		chk({gate, st}, 2'h3);
		want = 1'h0;
		cyc(20);
	endtask
	task automatic t_port_b;
		pr_b  = 1'h0;
		stk_b = 1'h1;
		want  = 1'h1;
		cyc(80);
		chk({gate, led}, 2'h3);
		want = 1'h0;
		pr_b = 1'h1;
		cyc(20);
		want = 1'h1;
		cyc(70);
		chk(gate, 1'h0);
		stk_b = 1'h0;
		want  = 1'h0;
		cyc(20);
		chk(led, 1'h1);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(20);
		rstn = 1'h1;
		t_power_up();
		t_on_off();
		t_short();
		t_uv();
		t_monitor();
		t_freeze();
		t_port_b();
		end_sim();
	end
	initial begin
		cyc(3000);
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
